/* hw/vcuc_pkg.sv */
// Package of constants and types for the adjust line counter control core.
package vcuc_pkg;
    // Clock rate in kilohertz, used to turn times into cycle counts.
    localparam int unsigned CLK_KHZ        = 100000;
    // Counter width and number of steps of the current setting.
    localparam int unsigned SET_W          = 7;
    localparam int unsigned SET_STEPS      = 128;
    // Setting limits.
    localparam logic [6:0]  SET_MIN        = 7'h00;
    localparam logic [6:0]  SET_MAX        = 7'h7F;
    // Reset value of the counter before the stored value is loaded.
    localparam logic [6:0]  SET_RST        = 7'h00;
    // Longest excursion that is rejected, in microseconds.
    localparam int unsigned REJECT_US      = 20;
    // Least width of a count or programming pulse, in microseconds.
    localparam int unsigned COUNT_US       = 200;
    // Longest time allowed for the internal memory write, in milliseconds.
    localparam int unsigned PROG_MS        = 100;
    // Cycle counts derived from the times above.
    localparam int unsigned REJECT_CYC     = REJECT_US * CLK_KHZ / 1000;
    localparam int unsigned COUNT_CYC      = COUNT_US * CLK_KHZ / 1000;
    localparam int unsigned PROG_CYC       = PROG_MS * CLK_KHZ;
    // Width of the pulse width counter.
    localparam int unsigned WID_W          = 16;

    // Decoded level of the four level adjust line.
    typedef enum logic [1:0] {
        VCUC_LVL_MID  = 2'b00,  // Idle middle level.
        VCUC_LVL_LOW  = 2'b01,  // Low level, count up.
        VCUC_LVL_HIGH = 2'b10,  // High level, count down.
        VCUC_LVL_PROG = 2'b11   // Programming level.
    } vcuc_lvl_t;
endpackage : vcuc_pkg

/* hw/vcuc_ctl.sv */
// Control core: pulse filter, saturating counter and memory commit.
// Operation
// - Count only while the gate is high.
// - Mid-to-low pulse increments the counter.
// - Mid-to-high pulse decrements the counter.
// - Programming level writes counter into memory.
// - Counter saturates at both ends.
// - Counter value drives the current DAC.
// - Stored value loads into counter at start.
// - Excursions under 20 us are rejected.
// - First detected count pulse after power-up ignored.
// - Held programming level writes within 100 ms.
module vcuc_ctl #(
    parameter int unsigned PROG_CYCLES   = vcuc_pkg::PROG_CYC,  // Write time.
    parameter int unsigned COUNT_CYCLES  = vcuc_pkg::COUNT_CYC, // Count width.
    parameter int unsigned REJECT_CYCLES = vcuc_pkg::REJECT_CYC // Glitch width.
) (
    input  wire logic                        clk_i,      // 100 MHz clock.
    input  wire logic                        rst_i,      // Async reset.
    input  wire logic [1:0]                  adj_lvl_i,  // Decoded line.
    input  wire logic                        gate_i,     // Count gate.
    input  wire logic [vcuc_pkg::SET_W-1:0]  nvm_val_i,  // Stored value.
    output logic [vcuc_pkg::SET_W-1:0]       dac_set_o,  // DAC setting.
    output logic                             nvm_we_o,   // Write strobe.
    output logic [vcuc_pkg::SET_W-1:0]       nvm_wdata_o, // Write data.
    output logic                             prog_busy_o // Write busy.
);
    import vcuc_pkg::*;

    // Pulse width counter saturates at the count width.
    localparam logic [WID_W-1:0] WID_REJ = WID_W'(REJECT_CYCLES);
    localparam logic [WID_W-1:0] WID_CNT = WID_W'(COUNT_CYCLES);

    vcuc_lvl_t               lvl;            // Current line level.
    vcuc_lvl_t               cur_q;          // Level of the running pulse.
    logic [WID_W-1:0]        wid_q;          // Width of the running pulse.
    logic                    armed_q;        // First pulse was discarded.
    logic                    loaded_q;       // Stored value was loaded.
    logic                    pulse_end;      // A pulse just ended.
    logic                    pulse_ok;       // Ended pulse is long enough.
    logic                    prog_req;       // Programming pulse qualified.
    logic [31:0]             prog_cnt_q;     // Write time counter.
    logic [SET_W-1:0]        cnt_q;          // The setting counter.
    logic [31:0]             busy_len_q;     // Busy cycles seen so far.

    assign lvl       = vcuc_lvl_t'(adj_lvl_i);
    // A pulse ends when the line leaves its non-middle level for any other level.
    assign pulse_end = (cur_q != VCUC_LVL_MID) && (lvl != cur_q);
    // Rejected and unspecified widths both fall short of the count width.
    assign pulse_ok  = (wid_q >= WID_CNT) && (wid_q > WID_REJ);
    // Programming needs the full width at the programming level.
    assign prog_req  = (cur_q == VCUC_LVL_PROG) && (wid_q == WID_CNT - 1)
                       && (lvl == VCUC_LVL_PROG);

    // Pulse tracker: measures how long the line stays off the middle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_q <= VCUC_LVL_MID;
            wid_q <= '0;
        end else if (lvl != cur_q) begin
            // A new level starts a new measurement.
            cur_q <= lvl;
            wid_q <= '0;
        end else if (wid_q != WID_CNT) begin
            // Count up to the count width and hold there.
            wid_q <= wid_q + 1'b1;
        end
    end

    // First count pulse after power-up is swallowed.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (pulse_end && cur_q != VCUC_LVL_PROG) begin
            armed_q <= 1'b1;
        end
    end

    // Setting counter with power-on load and saturation.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q    <= SET_RST;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            // Load the stored value on the first edge after reset.
            cnt_q    <= nvm_val_i;
            loaded_q <= 1'b1;
        end else if (pulse_end && pulse_ok && armed_q && gate_i) begin
            if (cur_q == VCUC_LVL_LOW && cnt_q != SET_MAX) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (cur_q == VCUC_LVL_HIGH && cnt_q != SET_MIN) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Memory commit: one write strobe, with busy raised in the same cycle and held for the write time.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nvm_we_o    <= 1'b0;
            nvm_wdata_o <= SET_RST;
            prog_busy_o <= 1'b0;
            prog_cnt_q  <= '0;
        end else begin
            nvm_we_o <= 1'b0;
            if (prog_busy_o) begin
                // Busy ends when the write time runs out.
                if (prog_cnt_q == PROG_CYCLES - 1) begin
                    prog_busy_o <= 1'b0;
                end
                prog_cnt_q <= prog_cnt_q + 1;
            end else if (prog_req && loaded_q) begin
                nvm_we_o    <= 1'b1;
                nvm_wdata_o <= cnt_q;
                prog_busy_o <= 1'b1;
                prog_cnt_q  <= '0;
            end
        end
    end

    // The DAC setting comes straight from a register.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dac_set_o <= SET_RST;
        end else begin
            dac_set_o <= cnt_q;
        end
    end

    // Gate low means no change of setting from a count pulse.
    a_gate_blocks: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && !gate_i |=> $stable(cnt_q))
        else $error("Counter moved with gate low.");
    // Increment by exactly one from a qualified low pulse.
    a_inc_step: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && pulse_end && pulse_ok && armed_q && gate_i
        && cur_q == VCUC_LVL_LOW && cnt_q != SET_MAX
        |=> cnt_q == $past(cnt_q) + 7'h01)
        else $error("Low pulse did not increment.");
    // Decrement by exactly one from a qualified high pulse.
    a_dec_step: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && pulse_end && pulse_ok && armed_q && gate_i
        && cur_q == VCUC_LVL_HIGH && cnt_q != SET_MIN
        |=> cnt_q == $past(cnt_q) - 7'h01)
        else $error("High pulse did not decrement.");
    // Writes carry the counter value.
    a_write_data: assert property (
        @(posedge clk_i) disable iff (rst_i)
        nvm_we_o |-> nvm_wdata_o == $past(cnt_q) && prog_busy_o)
        else $error("Write data differs from counter.");
    // No wrap at either end.
    a_no_wrap: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && $past(loaded_q) |-> !(($past(cnt_q) == SET_MAX
        && cnt_q == SET_MIN) || ($past(cnt_q) == SET_MIN
        && cnt_q == SET_MAX)))
        else $error("Counter wrapped.");
    // DAC follows the counter one cycle later.
    a_dac_follow: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> dac_set_o == $past(cnt_q))
        else $error("DAC setting lags wrongly.");
    // Stored value is loaded on the first cycle.
    a_power_load: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !loaded_q |=> cnt_q == $past(nvm_val_i) && loaded_q)
        else $error("Stored value not loaded.");
    // Short pulses never count.
    a_short_reject: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && pulse_end && wid_q < WID_CNT |=> $stable(cnt_q))
        else $error("Short pulse was counted.");
    // The first pulse after reset never counts.
    a_first_drop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && !armed_q |=> $stable(cnt_q))
        else $error("First pulse was counted.");

    // Length of the running busy period, counted apart from the write
    // timer so that the busy checks do not lean on the logic they guard.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_len_q <= '0;
        end else if (prog_busy_o) begin
            // Busy stands, so one more cycle is counted.
            busy_len_q <= busy_len_q + 32'h1;
        end else begin
            // Idle, ready to time the next write.
            busy_len_q <= '0;
        end
    end

    // A programming pulse that has just reached its full width.
    sequence s_prog_held;
        loaded_q && !prog_busy_o && cur_q == VCUC_LVL_PROG
        && lvl == VCUC_LVL_PROG && wid_q == WID_CNT - 1;
    endsequence
    // One write strobe together with busy, then the strobe drops.
    sequence s_commit;
        nvm_we_o && prog_busy_o ##1 !nvm_we_o;
    endsequence
    // A qualified low pulse that ends with the counter at the top.
    sequence s_up_at_top;
        loaded_q && pulse_end && pulse_ok && armed_q && gate_i
        && cur_q == VCUC_LVL_LOW && cnt_q == SET_MAX;
    endsequence
    // A qualified high pulse that ends with the counter at the bottom.
    sequence s_down_at_bottom;
        loaded_q && pulse_end && pulse_ok && armed_q && gate_i
        && cur_q == VCUC_LVL_HIGH && cnt_q == SET_MIN;
    endsequence

    // A full programming pulse writes once and raises busy.
    a_prog_commit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_prog_held |=> s_commit)
        else $error("Programming pulse did not commit.");
    // Busy stands for exactly the write time.
    a_busy_time: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(prog_busy_o) |-> busy_len_q == PROG_CYCLES)
        else $error("Write busy time is wrong.");
    // Busy never outlasts the write time.
    a_busy_bound: assert property (
        @(posedge clk_i) disable iff (rst_i)
        busy_len_q <= PROG_CYCLES)
        else $error("Write busy ran too long.");
    // An increment at the top leaves the maximum in place.
    a_top_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_up_at_top |=> cnt_q == SET_MAX)
        else $error("Counter left the top.");
    // A decrement at the bottom leaves the minimum in place.
    a_bottom_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_down_at_bottom |=> cnt_q == SET_MIN)
        else $error("Counter left the bottom.");
    // Widths between the glitch limit and the count width never count.
    a_mid_reject: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && pulse_end && wid_q > WID_REJ && wid_q < WID_CNT
        |=> $stable(cnt_q))
        else $error("Unspecified pulse width was counted.");
    // The end of a programming pulse leaves the setting alone.
    a_prog_still: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loaded_q && pulse_end && cur_q == VCUC_LVL_PROG |=> $stable(cnt_q))
        else $error("Programming pulse changed the setting.");
endmodule : vcuc_ctl

/* dv/vcuc_ctlr_model.sv */
// Model of the alignment controller that drives the adjust line and gate.
module vcuc_ctlr_model (
    input  wire logic       clk_i,      // Bench clock.
    output logic [1:0]      adj_lvl_o,  // Decoded adjust line level.
    output logic            gate_o      // Count gate.
);
    timeunit 1ns;
    timeprecision 1ps;
    import vcuc_pkg::*;
    // The line idles at the middle level with the gate closed.
    initial begin
        adj_lvl_o <= VCUC_LVL_MID;
        gate_o    <= 1'b0;
    end
    // Holds one level for a number of cycles, then returns to the middle.
    task automatic pulse(input logic [1:0] lvl, input int unsigned cyc,
                         input logic gate);
        @(posedge clk_i);
        gate_o    <= gate;
        adj_lvl_o <= lvl;
        repeat (cyc) @(posedge clk_i);
        adj_lvl_o <= VCUC_LVL_MID;
        repeat (1200) @(posedge clk_i);
        gate_o    <= 1'b0;
    endtask : pulse
endmodule : vcuc_ctlr_model

/* dv/test_vcuc_ctl.sv */
// Self-checking bench for the adjust line counter control core.
module test_vcuc_ctl;
    timeunit 1ns;
    timeprecision 1ps;
    import vcuc_pkg::*;
    // Pulse widths are scaled down tenfold to keep the run short.
    localparam int unsigned CNT_SIM = COUNT_CYC / 10;   // Count width.
    localparam int unsigned REJ_SIM = REJECT_CYC / 10;  // Glitch width.
    localparam int unsigned LONG    = CNT_SIM + 100;    // Valid pulse width.
    logic       clk_i = 1'b0;     // Bench clock.
    logic       rst_i = 1'b1;     // Reset, held at start.
    logic [1:0] adj_lvl;          // Line level from the model.
    logic       gate;             // Gate from the model.
    logic [6:0] nvm_val = 7'h7E;  // Stored value loaded at start.
    logic [6:0] dac_set;          // Setting seen at the DAC.
    logic [6:0] wdata;            // Write data from the design.
    logic [6:0] wd_seen;          // Data seen with the last strobe.
    logic       we;               // Write strobe.
    logic       busy;             // Write busy flag.
    int         fail_count = 0;   // Mismatches found.
    int         compares = 0;     // Comparisons made.
    int         we_n = 0;         // Write strobes seen.
    int         busy_n = 0;       // Busy cycles seen.
    // The clock toggles every half period of 5 ns.
    always #5 clk_i = ~clk_i;
    vcuc_ctlr_model ctl (.clk_i(clk_i), .adj_lvl_o(adj_lvl), .gate_o(gate));
    vcuc_ctl #(
        .PROG_CYCLES(50), .COUNT_CYCLES(CNT_SIM), .REJECT_CYCLES(REJ_SIM)
    ) dut (
        .clk_i(clk_i), .rst_i(rst_i), .adj_lvl_i(adj_lvl), .gate_i(gate),
        .nvm_val_i(nvm_val), .dac_set_o(dac_set), .nvm_we_o(we),
        .nvm_wdata_o(wdata), .prog_busy_o(busy));
    // Counts strobes and busy cycles on the falling edge, once settled.
    always @(negedge clk_i) begin
        if (we === 1'b1) begin
            we_n++;
            wd_seen = wdata;
        end
        if (busy === 1'b1) busy_n++;
    end
    // Compares a seen value with the expected one and reports a mismatch.
    task automatic check(string name, logic [6:0] seen, logic [6:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // The first valid pulse after reset is dropped.
    task automatic sc_first();
        ctl.pulse(VCUC_LVL_HIGH, LONG, 1'b1);
        check("first", dac_set, 7'h7E);
    endtask : sc_first
    // A low pulse counts up, and saturates at the top.
    task automatic sc_up();
        ctl.pulse(VCUC_LVL_LOW, LONG, 1'b1);
        check("up", dac_set, 7'h7F);
        ctl.pulse(VCUC_LVL_LOW, LONG, 1'b1);
        check("sat", dac_set, SET_MAX);
    endtask : sc_up
    // Rejected and too short pulses do not count.
    task automatic sc_short();
        ctl.pulse(VCUC_LVL_HIGH, REJ_SIM / 2, 1'b1);
        check("glitch", dac_set, 7'h7F);
        ctl.pulse(VCUC_LVL_HIGH, (REJ_SIM + CNT_SIM) / 2, 1'b1);
        check("narrow", dac_set, 7'h7F);
        ctl.pulse(VCUC_LVL_HIGH, CNT_SIM, 1'b1);
        check("edge", dac_set, 7'h7F);
    endtask : sc_short
    // A closed gate blocks a valid pulse; an open one counts down.
    task automatic sc_down();
        ctl.pulse(VCUC_LVL_HIGH, LONG, 1'b0);
        check("gated", dac_set, 7'h7F);
        ctl.pulse(VCUC_LVL_HIGH, LONG, 1'b1);
        check("down", dac_set, 7'h7E);
    endtask : sc_down
    // Programming level commits the count once, with a timed busy.
    task automatic sc_prog();
        ctl.pulse(VCUC_LVL_PROG, LONG, 1'b0);
        check("we", 7'(we_n), 7'h01);
        check("wdata", wd_seen, 7'h7E);
        check("busy", 7'(busy_n), 7'h32);
        check("hold", dac_set, 7'h7E);
    endtask : sc_prog
    // A reload from a low stored value, then steps down onto the floor.
    task automatic sc_floor();
        nvm_val <= 7'h01;
        rst_i   <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("reload", dac_set, 7'h01);
        ctl.pulse(VCUC_LVL_HIGH, LONG, 1'b1);
        check("rearm", dac_set, 7'h01);
        ctl.pulse(VCUC_LVL_HIGH, LONG, 1'b1);
        check("bottom", dac_set, SET_MIN);
        ctl.pulse(VCUC_LVL_HIGH, LONG, 1'b1);
        check("floor", dac_set, SET_MIN);
    endtask : sc_floor
    // Main sequence: reset for 8 cycles, then each scenario in turn.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("load", dac_set, 7'h7E);
        sc_first();
        sc_up();
        sc_short();
        sc_down();
        sc_prog();
        sc_floor();
        close_out();
    end
    // Watchdog: a hang counts as a mismatch and ends the run.
    initial begin
        repeat (90000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
endmodule : test_vcuc_ctl
